/* logic/sdwi_host.sv */
`timescale 1ns/100ps
module sdwi_host
   import sdwi_pkg::*;
(
   input  wire logic                           i_clk_sys,
   input  wire logic                           i_nrst,
   input  wire logic                           i_valid,
   input  wire logic [sdwi_pkg::CODE_BITS-1:0] i_code,
   input  wire logic [sdwi_pkg::MODE_BITS-1:0] i_mode,
   input  wire logic                           i_abort,
   output logic                                o_ready,
   output logic                                o_done,
   sdwi_if.host                                link
);
   // ****************************************************************
   // Sequencer
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_GAP  = 4'b0010,
      ST_SEND = 4'b0100,
      ST_END  = 4'b1000
   } sdwi_hst_t;

   sdwi_hst_t             st_r;
   logic [FRAME_BITS-1:0] shreg_r;
   logic [CNT_BITS-1:0]   bits_r;
   logic [DIV_BITS-1:0]   div_r;
   logic                  sel_r;
   logic                  sck_r;
   logic                  done_r;

   wire div_hit  = (div_r == DIV_LAST);
   wire gap_hit  = (div_r == GAP_LAST);
   wire last_bit = (bits_r == CNT_LAST - 5'h01);

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         st_r    <= ST_IDLE;
         shreg_r <= '0;
         bits_r  <= '0;
         div_r   <= '0;
         sel_r   <= 1'b0;
         sck_r   <= 1'b1;
         done_r  <= 1'b0;
      end else begin
         done_r <= 1'b0;
         unique case (st_r)
            ST_IDLE: begin
               div_r <= '0;
               if (i_valid) begin
                  shreg_r <= {2'b00, i_mode, i_code};
                  sel_r   <= 1'b1;
                  st_r    <= ST_GAP;
               end
            end
            ST_GAP: begin
               div_r <= div_r + 3'h1;
               if (gap_hit) begin
                  sel_r  <= 1'b0;
                  bits_r <= '0;
                  div_r  <= '0;
                  st_r   <= ST_SEND;
               end
            end
            ST_SEND: begin
               div_r <= div_r + 3'h1;
               if (i_abort) begin
                  div_r <= '0;
                  sel_r <= 1'b1;
                  sck_r <= 1'b1;
                  st_r  <= ST_END;
               end else if (div_hit) begin
                  div_r <= '0;
                  sck_r <= ~sck_r;
                  if (!sck_r) begin
                     shreg_r <= {shreg_r[FRAME_BITS-2:0], 1'b0};
                     bits_r  <= bits_r + 5'h01;
                     if (last_bit) begin
                        st_r <= ST_END;
                     end
                  end
               end
            end
            ST_END: begin
               if (sel_r && (div_r == '0)) begin
                  div_r <= 3'h1;
               end else begin
                  sel_r  <= 1'b0;
                  sck_r  <= 1'b1;
                  done_r <= ~sel_r;
                  st_r   <= ST_IDLE;
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

   assign o_ready    = (st_r == ST_IDLE);
   assign o_done     = done_r;
   assign link.sel_n = sel_r;
   assign link.sclk  = sck_r;
   assign link.sdata = shreg_r[FRAME_BITS-1];
endmodule

/* inc/sdwi_pkg.sv */
package sdwi_pkg;

   // ****************************************************************
   // Frame layout
   // ****************************************************************
   localparam int FRAME_BITS   = 16;
   localparam int CODE_BITS    = 12;
   localparam int MODE_BITS    = 2;
   localparam int MODE_HI_POS  = 13;
   localparam int MODE_LO_POS  = 12;
   localparam int CODE_MSB_POS = 11;
   localparam int CNT_BITS     = 5;
   localparam logic [CNT_BITS-1:0]  CNT_LAST   = 5'h10;
   localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
   localparam logic [CODE_BITS-1:0] CODE_MAX   = 12'hFFF;

   // ****************************************************************
   // Output stage modes
   // ****************************************************************
   typedef enum logic [1:0] {
      SDWI_MODE_NORMAL = 2'h0,
      SDWI_MODE_PD_1K  = 2'h1,
      SDWI_MODE_PD_100K = 2'h2,
      SDWI_MODE_PD_HIZ = 2'h3
   } sdwi_mode_t;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_SYS_NS     = 50;
   localparam int SEL_HIGH_MIN_NS = 33;
   localparam int SEL_HIGH_CYC   = (SEL_HIGH_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
   localparam int SCLK_HALF_CYC  = 4;
   localparam int DIV_BITS       = 3;
   localparam logic [DIV_BITS-1:0] DIV_LAST = 3'h3;
   localparam logic [DIV_BITS-1:0] GAP_LAST = 3'h1;

endpackage

/* inc/sdwi_if.sv */
`timescale 1ns/100ps
interface sdwi_if;
   logic sel_n;
   logic sclk;
   logic sdata;

   modport dev (input sel_n, input sclk, input sdata);
   modport host (output sel_n, output sclk, output sdata);
endinterface

/* logic/sdwi_dev.sv */
`timescale 1ns/100ps
// How it works
// - Frame select falling edge arms shift register.
// - Shift data on serial clock falling edges.
// - Sixteenth falling edge executes code and mode.
// - Host keeps select high at least 33 ns.
// - Host may idle select low between writes.
// - Two ignored bits, two mode, twelve code.
// - Early select rise discards frame entirely.
// - Reset clears code register to zero.
// - Mode bits pick normal or three power-downs.
// - Power-down disconnects amplifier, shuts down bias; here only o_amp_on drops, there is no bias signal.
// - Power-down keeps stored code unchanged; here a power-down write still loads its twelve code bits.
// - Host sends most significant bit first.
// - Byte hosts hold select low between bytes.
// - Code is straight binary zero to 4095.
// - Select may stay low after execution.
// - Serial clock at most 30 MHz.
module sdwi_dev
   import sdwi_pkg::*;
(
   input  wire logic                           i_clk_sys,
   input  wire logic                           i_nrst,
   sdwi_if.dev                                 link,
   output logic     [sdwi_pkg::CODE_BITS-1:0]  o_code,
   output sdwi_pkg::sdwi_mode_t                o_mode,
   output logic                                o_amp_on,
   output logic                                o_load_1k,
   output logic                                o_load_100k,
   output logic                                o_update
);
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [1:0] sel_s_r;
   logic [1:0] sck_s_r;
   logic [1:0] dat_s_r;
   logic       sel_d_r;
   logic       sck_d_r;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         sel_s_r <= 2'h0;
         sck_s_r <= 2'h0;
         dat_s_r <= 2'h0;
         sel_d_r <= 1'b0;
         sck_d_r <= 1'b0;
      end else begin
         sel_s_r <= {sel_s_r[0], link.sel_n};
         sck_s_r <= {sck_s_r[0], link.sclk};
         dat_s_r <= {dat_s_r[0], link.sdata};
         sel_d_r <= sel_s_r[1];
         sck_d_r <= sck_s_r[1];
      end
   end

   wire sel_low  = ~sel_s_r[1];
   wire sel_fall = sel_d_r & ~sel_s_r[1];
   wire sck_fall = sck_d_r & ~sck_s_r[1];

   // ****************************************************************
   // Frame capture
   // ****************************************************************
   logic [FRAME_BITS-1:0] shreg_r;
   logic [CNT_BITS-1:0]   cnt_r;
   logic                  armed_r;

   wire                  shift_en = armed_r & sel_low & sck_fall;
   wire [FRAME_BITS-1:0] shreg_nxt = {shreg_r[FRAME_BITS-2:0], dat_s_r[1]};
   wire                  done     = shift_en & (cnt_r == CNT_LAST - 5'h01);

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         shreg_r <= '0;
         cnt_r   <= '0;
         armed_r <= 1'b0;
      end else if (!sel_low) begin
         shreg_r <= '0;
         cnt_r   <= '0;
         armed_r <= 1'b0;
      end else if (sel_fall) begin
         armed_r <= 1'b1;
         cnt_r   <= '0;
      end else if (done) begin
         armed_r <= 1'b0;
         shreg_r <= shreg_nxt;
         cnt_r   <= CNT_LAST;
      end else if (shift_en) begin
         shreg_r <= shreg_nxt;
         cnt_r   <= cnt_r + 5'h01;
      end
   end

   // ****************************************************************
   // Execution and output stage
   // ****************************************************************
   logic [CODE_BITS-1:0] code_r;
   sdwi_mode_t           mode_r;
   logic                 upd_r;

   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         code_r <= CODE_RESET;
         mode_r <= SDWI_MODE_NORMAL;
         upd_r  <= 1'b0;
      end else begin
         upd_r <= done;
         if (done) begin
            code_r <= shreg_nxt[CODE_MSB_POS:0];
            mode_r <= sdwi_mode_t'({shreg_nxt[MODE_HI_POS], shreg_nxt[MODE_LO_POS]});
         end
      end
   end

   assign o_code      = code_r;
   assign o_mode      = mode_r;
   assign o_update    = upd_r;
   assign o_amp_on    = (mode_r == SDWI_MODE_NORMAL);
   assign o_load_1k   = (mode_r == SDWI_MODE_PD_1K);
   assign o_load_100k = (mode_r == SDWI_MODE_PD_100K);
endmodule

/* verif/sdwi_chk.sv */
`timescale 1ns/100ps
module sdwi_chk
   import sdwi_pkg::*;
(
   input wire logic                           i_clk_sys,
   input wire logic                           i_nrst,
   input wire logic                           sel_n,
   input wire logic                           sclk,
   input wire logic                           sdata,
   input wire logic [sdwi_pkg::CODE_BITS-1:0] o_code,
   input wire sdwi_pkg::sdwi_mode_t           o_mode,
   input wire logic                           o_amp_on,
   input wire logic                           o_load_1k,
   input wire logic                           o_load_100k,
   input wire logic                           o_update
);
   logic [4:0] fall_r;
   logic [2:0] low_r;

   // Counts the cycles of the current serial clock low phase.
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst || sclk) begin
         low_r <= 3'h0;
      end else if (low_r != 3'h7) begin
         low_r <= low_r + 3'h1;
      end
   end

   // Counts serial clock falls inside the current frame.
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst || sel_n) begin
         fall_r <= 5'h00;
      end else if ($fell(sclk)) begin
         fall_r <= fall_r + 5'h01;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   exec_after_16_a: assert property (($fell(sclk) && !sel_n && fall_r == 5'h0F) |-> ##3 o_update)
      else $error("no update three cycles after last edge");
   frame_len_a: assert property (o_update |-> $past(fall_r, 2) == 5'h10)
      else $error("update without a full frame");
   code_hold_a: assert property ($changed(o_code) |-> o_update)
      else $error("code changed without update");
   mode_hold_a: assert property ($changed(o_mode) |-> o_update)
      else $error("mode changed without update");
   amp_decode_a: assert property (o_amp_on == (o_mode == SDWI_MODE_NORMAL))
      else $error("amplifier enable wrong for mode");
   load_decode_a: assert property ({o_load_1k, o_load_100k} == {o_mode == SDWI_MODE_PD_1K, o_mode == SDWI_MODE_PD_100K})
      else $error("load select wrong for mode");
   update_pulse_a: assert property (o_update |=> !o_update)
      else $error("update longer than one cycle");
   sel_gap_a: assert property ($rose(sel_n) |=> sel_n)
      else $error("select high too short");
   sel_start_a: assert property ($fell(sel_n) |-> sclk)
      else $error("frame started with clock low");
   sclk_half_a: assert property (($rose(sclk) && !sel_n) |-> low_r >= 3'h4)
      else $error("serial clock low phase too short");

   cover property ($rose(sel_n) && fall_r != 5'h00);
   cover property (o_update && o_mode == SDWI_MODE_PD_HIZ);
   cover property (o_update && o_code == CODE_MAX && sdata == 1'b1);
endmodule

/* verif/tb_serial_dac_write_interface.sv */
`timescale 1ns/100ps
module tb_serial_dac_write_interface;
   import sdwi_pkg::*;
   logic        i_clk_sys = 1'b0;
   logic        i_nrst    = 1'b0;
   logic        i_valid   = 1'b0;
   logic        i_abort   = 1'b0;
   logic [11:0] i_code    = 12'h000;
   logic [1:0]  i_mode    = 2'h0;
   logic        o_ready, o_done, o_amp_on, o_load_1k, o_load_100k, o_update;
   logic [11:0] o_code, exp_code;
   sdwi_mode_t  o_mode;
   logic [1:0]  exp_mode;
   logic [15:0] seed      = 16'h0057;
   logic [15:0] wire_r    = 16'h0000;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cyc       = 0;
   int          done_cnt  = 0;

   always @(posedge i_clk_sys) begin
      if (o_done === 1'b1) begin
         done_cnt <= done_cnt + 1;
      end
   end

   always #25 i_clk_sys = ~i_clk_sys;
   sdwi_if sdwi_if_inst ();
   sdwi_host sdwi_host_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_valid(i_valid), .i_code(i_code),
      .i_mode(i_mode), .i_abort(i_abort), .o_ready(o_ready), .o_done(o_done), .link(sdwi_if_inst));
   sdwi_dev sdwi_dev_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .link(sdwi_if_inst), .o_code(o_code),
      .o_mode(o_mode), .o_amp_on(o_amp_on), .o_load_1k(o_load_1k), .o_load_100k(o_load_100k), .o_update(o_update));
   sdwi_chk sdwi_chk_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .sel_n(sdwi_if_inst.sel_n),
      .sclk(sdwi_if_inst.sclk), .sdata(sdwi_if_inst.sdata), .o_code(o_code), .o_mode(o_mode), .o_amp_on(o_amp_on),
      .o_load_1k(o_load_1k), .o_load_100k(o_load_100k), .o_update(o_update));

   // Shifts in the wire bits at each falling serial clock within a frame.
   always @(negedge sdwi_if_inst.sclk) begin
      if (!sdwi_if_inst.sel_n) begin
         wire_r <= {wire_r[14:0], sdwi_if_inst.sdata};
      end
   end

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [2:0] exp_stage(input logic [1:0] m);
      return {m == 2'h0, m == 2'h1, m == 2'h2};
   endfunction

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A cut above zero raises abort that many cycles into the frame.
   task automatic send(input logic [11:0] c, input logic [1:0] m, input int cut);
      int n;
      int d0;
      d0 = done_cnt;
      @(posedge i_clk_sys);
      i_valid <= 1'b1;
      i_code  <= c;
      i_mode  <= m;
      @(posedge i_clk_sys);
      i_valid <= 1'b0;
      if (cut > 0) begin
         repeat (cut) @(posedge i_clk_sys);
         i_abort <= 1'b1;
         repeat (4) @(posedge i_clk_sys);
         i_abort <= 1'b0;
      end else begin
         exp_code = c;
         exp_mode = m;
      end
      @(negedge i_clk_sys);
      n = 0;
      while (o_ready !== 1'b1 && n < 400) begin
         @(negedge i_clk_sys);
         n++;
      end
      repeat (6) @(negedge i_clk_sys);
      if (cut == 0) begin
         check("frame", wire_r, {2'b00, m, c});
      end
      check("ready", {15'h0, o_ready}, 16'h0001);
      check("done", 16'(done_cnt - d0), {15'h0, cut == 0});
      check("code", {4'h0, o_code}, {4'h0, exp_code});
      check("mode", {14'h0, o_mode}, {14'h0, exp_mode});
      check("stage", {13'h0, o_amp_on, o_load_1k, o_load_100k}, {13'h0, exp_stage(exp_mode)});
   endtask

   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         finish_test();
      end
   end

   initial begin
      exp_code = 12'h000;
      exp_mode = 2'h0;
      repeat (8) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      @(negedge i_clk_sys);
      check("reset code", {4'h0, o_code}, 16'h0000);
      check("reset stage", {13'h0, o_amp_on, o_load_1k, o_load_100k}, 16'h0004);
      send(12'h123, 2'h1, 1);
      for (int m = 0; m < 4; m++) begin
         send(12'hFFF >> (4 * m), m[1:0], 0);
      end
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         send(seed[11:0], seed[13:12], seed[14] ? 0 : 20 + int'(seed[5:0]));
      end
      send(12'h5A5, 2'h3, 100);
      send(12'h800, 2'h0, 0);
      finish_test();
   end
endmodule
